// ==== verilog/irq_resolver_defs.svh ====
// Constants for the interrupt priority resolver and its mode register
`ifndef IRQ_RESOLVER_DEFS_SVH
`define IRQ_RESOLVER_DEFS_SVH

// Priority and mode register address
`define PMR_ADDR 16'h103C
// Field positions within the priority and mode register
`define PMR_BOOT_BIT 7
`define PMR_SPECIAL_BIT 6
`define PMR_MODE_A_BIT 5
`define PMR_VIS_BIT 4
`define PMR_SEL_MSB 3
`define PMR_SEL_LSB 0
// Reset value of the priority select field
`define SEL_RESET 4'h5
// Reserved select code and the source it falls back to
`define SEL_RESERVED 4'h5
`define SEL_EXTERNAL 4'h6
// Boot ROM window, 192 bytes
`define BOOT_ROM_LO 16'hBF40
`define BOOT_ROM_HI 16'hBFFF
// Index of the last stacked byte (condition codes)
`define STACK_LAST 4'h8
// Read data for an unmapped address
`define UNMAPPED_DATA 8'h00

`endif

// ==== verilog/irq_resolver_pkg.sv ====
// Types shared by the interrupt priority resolver
package irq_resolver_pkg;

    // Source chosen by the resolution step
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_RESET,
        SRC_CLK_MON,
        SRC_WATCHDOG,
        SRC_SWI,
        SRC_ILLEGAL,
        SRC_NMI,
        SRC_MASKABLE
    } src_t;

    // Stack bytes, in push order
    typedef enum logic [3:0] {
        STK_PCL, STK_PCH, STK_IYL, STK_IYH, STK_IXL, STK_IXH,
        STK_ACCA, STK_ACCB, STK_CCR
    } stack_item_t;

endpackage : irq_resolver_pkg

// ==== verilog/interrupt_priority_resolver.sv ====
// Interrupt stacking, priority resolution and mode register
`timescale 1ns/1ns
`include "irq_resolver_defs.svh"

// Functional notes
// - Resolve pending requests only after condition codes pushed
// - Newer higher request wins at resolution time
// - Fixed order: reset, clock, watchdog, illegal, pin
// - Fetched software interrupt ranks just below reset
// - Select field promotes one maskable source
// - Nonmaskable sources outrank the promoted source
// - Promoted source still obeys enables and mask
// - Promotion never changes the fetched vector
// - Codes 0-7: timer, pulse, spi, serial, external, rti
// - Codes 8-15: input captures 1-3, compares 1-5
// - Register always readable; upper bits need special
// - Select field writable only while mask set
// - Boot ROM at BF40-BFFF only when enabled
// - Boot enable zero after test reset, settable
// - Special flag clears but never sets again
// - Mode A bit writable only in special mode
// - Read visibility writable in special, else zero
// - Visibility drives internal reads onto external bus
// - Return unstacks everything, program counter last
// - Push PCL,PCH,IYL,IYH,IXL,IXH,A,B,CONDITION_CODE_REGISTER in order
// - Maskable sets I; pin sets I and X
module interrupt_priority_resolver #(
    parameter int MASK_SRCS = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Mode straps caught at reset
    input wire logic strap_special,
    input wire logic strap_mode_a,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_ff,
    // Condition code state from the core
    input wire logic ccr_i_bit,
    input wire logic ccr_x_bit,
    // Requests
    input wire logic reset_req,
    input wire logic clock_monitor_req,
    input wire logic watchdog_failure,
    input wire logic illegal_opcode_req,
    input wire logic nonmaskable_request_pin_n,
    input wire logic [MASK_SRCS-1:0] maskable_req,
    // Core sequencing
    input wire logic entry_start,
    input wire logic software_interrupt_instr,
    input wire logic return_from_interrupt_instr,
    // Stack traffic
    output logic push_strobe_ff,
    output logic pull_strobe_ff,
    output irq_resolver_pkg::stack_item_t stack_item_ff,
    output logic unstack_done_ff,
    // Vector selection
    output logic vector_valid_ff,
    output irq_resolver_pkg::src_t vector_src_ff,
    output logic [3:0] vector_mask_idx_ff,
    output logic set_i_ff,
    output logic set_x_ff,
    // Memory map and external bus
    input wire logic [15:0] cpu_addr,
    input wire logic internal_read,
    input wire logic [7:0] internal_rdata,
    output logic boot_rom_sel_ff,
    output logic ext_data_oe_ff,
    output logic [7:0] ext_data_out_ff,
    // Mode state
    output logic special_mode_flag_ff,
    output logic mode_a_select_ff
);
    import irq_resolver_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    typedef enum logic [2:0] {
        ST_IDLE, ST_PUSH, ST_RESOLVE, ST_PULL
    } seq_state_t;

    seq_state_t state_ff;
    logic [3:0] count_ff;
    logic boot_rom_enable_ff;
    logic internal_read_visibility_ff;
    logic [3:0] priority_select_field_ff;
    logic swi_lock_ff;
    logic i_entry_ff;
    logic x_entry_ff;
    logic [7:0] pmr_value;
    logic pmr_wr;
    logic mask_found;
    logic [3:0] mask_idx;
    src_t nxt_src;

    // Ranks 0-9 give codes 6-15, ranks 10-14 give codes 0-4
    function automatic logic [3:0] default_code(input logic [3:0] rank);
        return (rank < 4'hA) ? rank + 4'h6 : rank - 4'hA;
    endfunction : default_code

    // Map a select code to the source it promotes
    function automatic logic [3:0] promoted_code(input logic [3:0] sel);
        return (sel == `SEL_RESERVED) ? `SEL_EXTERNAL : sel;
    endfunction : promoted_code

    ////////////////////////////////////////////////////////////////////////
    // Priority and mode register
    assign pmr_wr = reg_wr && (reg_addr == `PMR_ADDR);
    // Visibility reads as zero at once when the special flag drops
    assign pmr_value = {boot_rom_enable_ff, special_mode_flag_ff,
                        mode_a_select_ff, (internal_read_visibility_ff &&
                        special_mode_flag_ff), priority_select_field_ff};

    // Special flag: straps at reset, clear-only afterwards
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            special_mode_flag_ff <= strap_special;
        end else if (pmr_wr && !reg_wdata[`PMR_SPECIAL_BIT]) begin
            special_mode_flag_ff <= 1'b0;
        end
    end

    // Upper bits, writable in special mode only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_a_select_ff <= strap_mode_a;
            boot_rom_enable_ff <= strap_special && !strap_mode_a;
            internal_read_visibility_ff <= 1'b0;
        end else begin
            if (pmr_wr && special_mode_flag_ff) begin
                mode_a_select_ff <= reg_wdata[`PMR_MODE_A_BIT];
                boot_rom_enable_ff <= reg_wdata[`PMR_BOOT_BIT];
            end
            if (!special_mode_flag_ff) begin
                internal_read_visibility_ff <= 1'b0;
            end else if (pmr_wr) begin
                internal_read_visibility_ff <= reg_wdata[`PMR_VIS_BIT];
            end
        end
    end

    // Select field, writable only while the maskable bit is set
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            priority_select_field_ff <= `SEL_RESET;
        end else if (pmr_wr && ccr_i_bit) begin
            priority_select_field_ff <=
                reg_wdata[`PMR_SEL_MSB:`PMR_SEL_LSB];
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata_ff <= `UNMAPPED_DATA;
        end else if (reg_rd && reg_addr == `PMR_ADDR) begin
            reg_rdata_ff <= pmr_value;
        end else begin
            reg_rdata_ff <= `UNMAPPED_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory map and read visibility
    // Boot ROM select
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            boot_rom_sel_ff <= 1'b0;
        end else begin
            boot_rom_sel_ff <= boot_rom_enable_ff &&
                cpu_addr >= `BOOT_ROM_LO && cpu_addr <= `BOOT_ROM_HI;
        end
    end

    // Drive internal read data out while visibility is on
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_data_oe_ff <= 1'b0;
            ext_data_out_ff <= 8'h00;
        end else begin
            ext_data_oe_ff <= internal_read_visibility_ff &&
                              special_mode_flag_ff && internal_read;
            ext_data_out_ff <= internal_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Resolution
    // Promoted source first, then default order
    always_comb begin
        logic [3:0] code;
        code = promoted_code(priority_select_field_ff);
        mask_found = 1'b0;
        mask_idx = 4'h0;
        if (maskable_req[code]) begin
            mask_found = 1'b1;
            mask_idx = code;
        end else begin
            for (int r = 0; r < 15; r++) begin
                code = default_code(4'(r));
                if (!mask_found && maskable_req[code]) begin
                    mask_found = 1'b1;
                    mask_idx = code;
                end
            end
        end
    end

    // Fixed order ahead of any maskable source
    always_comb begin
        nxt_src = SRC_NONE;
        if (reset_req) begin
            nxt_src = SRC_RESET;
        end else if (swi_lock_ff) begin
            nxt_src = SRC_SWI;
        end else if (clock_monitor_req) begin
            nxt_src = SRC_CLK_MON;
        end else if (watchdog_failure) begin
            nxt_src = SRC_WATCHDOG;
        end else if (illegal_opcode_req) begin
            nxt_src = SRC_ILLEGAL;
        end else if (!nonmaskable_request_pin_n && !x_entry_ff) begin
            nxt_src = SRC_NMI;
        end else if (mask_found && !i_entry_ff) begin
            nxt_src = SRC_MASKABLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    // Entry pushes, resolution, and return pulls
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            count_ff <= 4'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    count_ff <= 4'h0;
                    if (entry_start) begin
                        state_ff <= ST_PUSH;
                    end else if (return_from_interrupt_instr) begin
                        state_ff <= ST_PULL;
                    end
                end
                ST_PUSH: begin
                    count_ff <= count_ff + 4'h1;
                    if (count_ff == `STACK_LAST) begin
                        state_ff <= ST_RESOLVE;
                    end
                end
                ST_RESOLVE: begin
                    state_ff <= ST_IDLE;
                end
                ST_PULL: begin
                    count_ff <= count_ff + 4'h1;
                    if (count_ff == `STACK_LAST) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Mask bits as stacked at entry
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            i_entry_ff <= 1'b1;
            x_entry_ff <= 1'b1;
        end else if (state_ff == ST_IDLE && entry_start) begin
            i_entry_ff <= ccr_i_bit;
            x_entry_ff <= ccr_x_bit;
        end
    end

    // Software interrupt lock until its vector is issued
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            swi_lock_ff <= 1'b0;
        end else if (software_interrupt_instr) begin
            swi_lock_ff <= 1'b1;
        end else if (state_ff == ST_RESOLVE && nxt_src == SRC_SWI) begin
            swi_lock_ff <= 1'b0;
        end
    end

    // Stack strobes and byte selector
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            push_strobe_ff <= 1'b0;
            pull_strobe_ff <= 1'b0;
            stack_item_ff <= STK_PCL;
            unstack_done_ff <= 1'b0;
        end else begin
            push_strobe_ff <= state_ff == ST_PUSH;
            pull_strobe_ff <= state_ff == ST_PULL;
            unstack_done_ff <= state_ff == ST_PULL &&
                               count_ff == `STACK_LAST;
            if (state_ff == ST_PUSH) begin
                stack_item_ff <= stack_item_t'(count_ff);
            end else if (state_ff == ST_PULL) begin
                stack_item_ff <=
                    stack_item_t'(`STACK_LAST - count_ff);
            end
        end
    end

    // Vector and mask-bit updates after resolution
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vector_valid_ff <= 1'b0;
            vector_src_ff <= SRC_NONE;
            vector_mask_idx_ff <= 4'h0;
            set_i_ff <= 1'b0;
            set_x_ff <= 1'b0;
        end else begin
            vector_valid_ff <= state_ff == ST_RESOLVE;
            set_i_ff <= state_ff == ST_RESOLVE &&
                        nxt_src != SRC_NONE;
            set_x_ff <= state_ff == ST_RESOLVE && nxt_src == SRC_NMI;
            if (state_ff == ST_RESOLVE) begin
                vector_src_ff <= nxt_src;
                vector_mask_idx_ff <= mask_idx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_resolve_after_ccr;
        @(posedge sys_clk) disable iff (rst)
        (push_strobe_ff && stack_item_ff == STK_CCR) |=> vector_valid_ff;
    endproperty
    a_resolve_after_ccr: assert property (p_resolve_after_ccr)
        else $error("vector not issued right after condition code push");
    property p_push_sequence;
        @(posedge sys_clk) disable iff (rst)
        (state_ff == ST_IDLE && entry_start) |=> ##1
        (push_strobe_ff && stack_item_ff == STK_PCL) [*1] ##8
        (push_strobe_ff && stack_item_ff == STK_CCR);
    endproperty
    a_push_sequence: assert property (p_push_sequence)
        else $error("push sequence order wrong");
    property p_pull_pc_last;
        @(posedge sys_clk) disable iff (rst)
        unstack_done_ff |-> pull_strobe_ff && stack_item_ff == STK_PCL;
    endproperty
    a_pull_pc_last: assert property (p_pull_pc_last)
        else $error("program counter not pulled last");
    property p_reset_first;
        @(posedge sys_clk) disable iff (rst)
        (state_ff == ST_RESOLVE && reset_req) |=> vector_src_ff == SRC_RESET;
    endproperty
    a_reset_first: assert property (p_reset_first)
        else $error("reset not resolved first");
    property p_nmi_sets_x;
        @(posedge sys_clk) disable iff (rst)
        vector_valid_ff |-> (set_x_ff == (vector_src_ff == SRC_NMI)) &&
            (set_i_ff == (vector_src_ff != SRC_NONE));
    endproperty
    a_nmi_sets_x: assert property (p_nmi_sets_x)
        else $error("mask bits set wrongly after resolution");
    property p_special_mode_flag_no_set;
        @(posedge sys_clk) disable iff (rst)
        !special_mode_flag_ff |=> !special_mode_flag_ff;
    endproperty
    a_special_mode_flag_no_set: assert property (p_special_mode_flag_no_set)
        else $error("special flag set again");
    property p_irv_forced;
        @(posedge sys_clk) disable iff (rst)
        !special_mode_flag_ff |=> !internal_read_visibility_ff;
    endproperty
    a_irv_forced: assert property (p_irv_forced)
        else $error("visibility not forced off");
    property p_psel_locked;
        @(posedge sys_clk) disable iff (rst)
        (pmr_wr && !ccr_i_bit) |=> $stable(priority_select_field_ff);
    endproperty
    a_psel_locked: assert property (p_psel_locked)
        else $error("select field written with mask clear");
    property p_boot_window;
        @(posedge sys_clk) disable iff (rst)
        boot_rom_sel_ff |-> $past(boot_rom_enable_ff) &&
            $past(cpu_addr) >= `BOOT_ROM_LO && $past(cpu_addr) <= `BOOT_ROM_HI;
    endproperty
    a_boot_window: assert property (p_boot_window)
        else $error("boot ROM selected outside its window");
    property p_masked_quiet;
        @(posedge sys_clk) disable iff (rst)
        (state_ff == ST_RESOLVE && i_entry_ff) |=>
            vector_src_ff != SRC_MASKABLE;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("masked source was vectored");

endmodule : interrupt_priority_resolver

// ==== verification/cpu_core_model.sv ====
// CPU core stand-in: starts entry and return, logs stack traffic
`timescale 1ns/1ns
module cpu_core_model (
    // Clock
    input wire logic sys_clk,
    // Stack traffic from the resolver
    input wire logic push_strobe_ff,
    input wire logic pull_strobe_ff,
    input wire logic unstack_done_ff,
    input wire irq_resolver_pkg::stack_item_t stack_item_ff,
    // Sequencing towards the resolver
    output logic entry_start,
    output logic return_from_interrupt_instr,
    output logic software_interrupt_instr
);
    import irq_resolver_pkg::*;

    stack_item_t push_log[$];
    stack_item_t pull_log[$];
    stack_item_t done_item = STK_CCR;

    // Sequencing lines idle low
    initial begin
        entry_start = 1'b0;
        return_from_interrupt_instr = 1'b0;
        software_interrupt_instr = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One-cycle pulse: 0 entry, 1 return, 2 software interrupt
    task automatic strobe(input logic [1:0] which);
        @(posedge sys_clk);
        entry_start <= (which == 2'd0);
        return_from_interrupt_instr <= (which == 2'd1);
        software_interrupt_instr <= (which == 2'd2);
        @(posedge sys_clk);
        entry_start <= 1'b0;
        return_from_interrupt_instr <= 1'b0;
        software_interrupt_instr <= 1'b0;
    endtask : strobe

    ////////////////////////////////////////////////////////////////////////
    // Stack memory side: record every byte moved
    always @(posedge sys_clk) begin
        if (push_strobe_ff)
            push_log.push_back(stack_item_ff);
        if (pull_strobe_ff)
            pull_log.push_back(stack_item_ff);
        if (unstack_done_ff)
            done_item = stack_item_ff;
    end
endmodule : cpu_core_model

// ==== verification/tb.sv ====
// Self-checking bench for the interrupt priority resolver
`timescale 1ns/1ns
`include "irq_resolver_defs.svh"
module tb;
    import irq_resolver_pkg::*;

    // Inputs of the design
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic strap_special = 1'b1;
    logic strap_mode_a = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ccr_i_bit = 1'b1;
    logic ccr_x_bit = 1'b1;
    logic reset_req = 1'b0;
    logic clock_monitor_req = 1'b0;
    logic watchdog_failure = 1'b0;
    logic illegal_opcode_req = 1'b0;
    logic nonmaskable_request_pin_n = 1'b1;
    logic [15:0] maskable_req = 16'h0000;
    logic [15:0] cpu_addr = 16'h0000;
    logic internal_read = 1'b0;
    logic [7:0] internal_rdata = 8'h00;
    // Outputs of the design and the core model
    logic entry_start, software_interrupt_instr, return_from_interrupt_instr;
    logic [7:0] reg_rdata_ff, ext_data_out_ff;
    logic push_strobe_ff, pull_strobe_ff, unstack_done_ff, vector_valid_ff;
    logic set_i_ff, set_x_ff, boot_rom_sel_ff, ext_data_oe_ff;
    logic special_mode_flag_ff, mode_a_select_ff;
    logic [3:0] vector_mask_idx_ff;
    stack_item_t stack_item_ff;
    src_t vector_src_ff;
    int fails = 0;
    int checks = 0;

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    interrupt_priority_resolver dut_u (
        .sys_clk, .rst, .strap_special, .strap_mode_a, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .ccr_i_bit,
        .ccr_x_bit, .reset_req, .clock_monitor_req, .watchdog_failure,
        .illegal_opcode_req, .nonmaskable_request_pin_n, .maskable_req,
        .entry_start, .software_interrupt_instr,
        .return_from_interrupt_instr, .push_strobe_ff, .pull_strobe_ff,
        .stack_item_ff, .unstack_done_ff, .vector_valid_ff,
        .vector_src_ff, .vector_mask_idx_ff, .set_i_ff, .set_x_ff,
        .cpu_addr, .internal_read, .internal_rdata, .boot_rom_sel_ff,
        .ext_data_oe_ff, .ext_data_out_ff, .special_mode_flag_ff,
        .mode_a_select_ff
    );

    cpu_core_model cpu_u (
        .sys_clk, .push_strobe_ff, .pull_strobe_ff, .unstack_done_ff,
        .stack_item_ff, .entry_start, .return_from_interrupt_instr,
        .software_interrupt_instr
    );

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s seen %0h expected %0h",
                     $time, what, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // Synchronous reset with mode straps
    task automatic do_reset(input logic sp, input logic ma);
        strap_special <= sp;
        strap_mode_a <= ma;
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : do_reset

    // Register write, one cycle
    task automatic reg_write(input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= `PMR_ADDR;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Register read, data judged in the cycle after the strobe
    task automatic reg_check(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        check(reg_rdata_ff, exp, "register read");
    endtask : reg_check

    // Boot ROM decode for one address
    task automatic boot_check(input logic [15:0] a, input logic exp);
        @(posedge sys_clk);
        cpu_addr <= a;
        repeat (2) @(posedge sys_clk);
        check(boot_rom_sel_ff, exp, "boot select");
    endtask : boot_check

    // Internal read shown on the external bus or not
    task automatic vis_check(input logic on);
        @(posedge sys_clk);
        internal_read <= 1'b1;
        internal_rdata <= 8'hA5;
        @(posedge sys_clk);
        internal_read <= 1'b0;
        @(posedge sys_clk);
        check(ext_data_oe_ff, on, "bus drive");
        if (on)
            check(ext_data_out_ff, 8'hA5, "bus data");
    endtask : vis_check

    // Nonmaskable requests: reset, clock, watchdog, illegal, pin
    task automatic set_nm(input logic [4:0] v);
        @(posedge sys_clk);
        reset_req <= v[4];
        clock_monitor_req <= v[3];
        watchdog_failure <= v[2];
        illegal_opcode_req <= v[1];
        nonmaskable_request_pin_n <= ~v[0];
    endtask : set_nm

    // One interrupt entry, judged on stacking and vector
    task automatic run_entry(input src_t src, input logic [3:0] idx,
                             input logic late);
        int n;
        cpu_u.push_log.delete();
        cpu_u.strobe(2'd0);
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (late && n == 3)
                illegal_opcode_req <= 1'b1;
            if (vector_valid_ff === 1'b1)
                break;
        end
        check(vector_valid_ff, 1'b1, "vector pulse");
        check(vector_src_ff, src, "source");
        if (src == SRC_MASKABLE)
            check(vector_mask_idx_ff, idx, "mask index");
        check(set_i_ff, src != SRC_NONE, "set I");
        check(set_x_ff, src == SRC_NMI, "set X");
        check(cpu_u.push_log.size(), 9, "push count");
        for (n = 0; n < 9; n++)
            check(cpu_u.push_log[n], n, "push order");
    endtask : run_entry

    ////////////////////////////////////////////////////////////////////////
    // Mode register, boot ROM window and read visibility
    task automatic t_regs();
        reg_check(`PMR_ADDR, 8'hC5);
        ccr_i_bit <= 1'b0;
        reg_write(8'hDA);
        reg_check(`PMR_ADDR, 8'hD5);
        boot_check(16'hBF3F, 1'b0);
        boot_check(`BOOT_ROM_LO, 1'b1);
        boot_check(`BOOT_ROM_HI, 1'b1);
        boot_check(16'hC000, 1'b0);
        vis_check(1'b1);
        ccr_i_bit <= 1'b1;
        reg_write(8'h13);
        reg_check(`PMR_ADDR, 8'h03);
        check(special_mode_flag_ff, 1'b0, "special flag");
        boot_check(`BOOT_ROM_LO, 1'b0);
        vis_check(1'b0);
        reg_write(8'hF7);
        reg_check(`PMR_ADDR, 8'h07);
        reg_check(16'h103D, `UNMAPPED_DATA);
        do_reset(1'b1, 1'b1);
        reg_check(`PMR_ADDR, 8'h65);
        reg_write(8'hE5);
        reg_check(`PMR_ADDR, 8'hE5);
        reg_write(8'h45);
        reg_check(`PMR_ADDR, 8'h45);
        check(mode_a_select_ff, 1'b0, "mode A");
    endtask : t_regs

    // Fixed order, software interrupt lock, mask, late request, return
    task automatic t_order();
        int i;
        src_t order[5];
        order = '{SRC_RESET, SRC_CLK_MON, SRC_WATCHDOG, SRC_ILLEGAL, SRC_NMI};
        ccr_i_bit <= 1'b0;
        ccr_x_bit <= 1'b0;
        maskable_req <= 16'hFFFF;
        for (i = 0; i < 5; i++) begin
            set_nm(5'h1F >> i);
            run_entry(order[i], 4'h0, 1'b0);
        end
        set_nm(5'h08);
        cpu_u.strobe(2'd2);
        run_entry(SRC_SWI, 4'h0, 1'b0);
        set_nm(5'h00);
        ccr_i_bit <= 1'b1;
        run_entry(SRC_NONE, 4'h0, 1'b0);
        ccr_i_bit <= 1'b0;
        maskable_req <= 16'h0001;
        run_entry(SRC_ILLEGAL, 4'h0, 1'b1);
        illegal_opcode_req <= 1'b0;
        cpu_u.pull_log.delete();
        cpu_u.strobe(2'd1);
        repeat (12) @(posedge sys_clk);
        check(cpu_u.pull_log.size(), 9, "pull count");
        for (i = 0; i < 9; i++)
            check(cpu_u.pull_log[i], 8 - i, "pull order");
        check(cpu_u.done_item, STK_PCL, "last pull");
    endtask : t_order

    // Every select code promotes its own source, reserved code 5 the external one
    task automatic t_promote();
        int c;
        logic [3:0] code;
        for (c = 0; c < 16; c++) begin
            code = 4'(c);
            ccr_i_bit <= 1'b1;
            reg_write({4'h4, code});
            ccr_i_bit <= 1'b0;
            maskable_req <= 16'hFFFF;
            if (code == `SEL_RESERVED)
                code = `SEL_EXTERNAL;
            run_entry(SRC_MASKABLE, code, 1'b0);
        end
        maskable_req <= 16'h0050;
        run_entry(SRC_MASKABLE, 4'h6, 1'b0);
        set_nm(5'h01);
        maskable_req <= 16'hFFFF;
        run_entry(SRC_NMI, 4'h0, 1'b0);
    endtask : t_promote

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        do_reset(1'b1, 1'b0);
        t_regs();
        t_order();
        t_promote();
        print_verdict();
    end

    // Watchdog: far beyond the few hundred cycles the tests need
    initial begin
        #3000000;
        fails++;
        print_verdict();
    end
endmodule : tb
